/* design/ccic_pkg.sv */
`default_nettype none
package ccic_pkg;

    // Oscillator clock period in nanoseconds.
    localparam int CLK_NS = 40;

    // Register offsets.
    localparam logic [7:0] A_THR_HI = 8'h05;
    localparam logic [7:0] A_THR_LO = 8'h06;
    localparam logic [7:0] A_WDOG   = 8'h07;
    localparam logic [7:0] A_CTL1   = 8'h08;
    localparam logic [7:0] A_CTL2   = 8'h09;
    localparam logic [7:0] A_HIGH   = 8'h0A;
    localparam logic [7:0] A_LOW    = 8'h0B;

    // Reset values.
    localparam logic [7:0] R_THR_HI = 8'h01;
    localparam logic [7:0] R_THR_LO = 8'h00;
    localparam logic [7:0] R_WDOG   = 8'hFE;
    localparam logic [7:0] R_CTL1   = 8'h1C;
    localparam logic [7:0] R_CTL2   = 8'h10;
    localparam logic [7:0] R_HIGH   = 8'h7A;
    localparam logic [7:0] R_LOW    = 8'h7A;
    localparam logic [7:0] R_ZERO   = 8'h00;

    // Field positions.
    localparam int B_WD_OFF   = 0;
    localparam int WD_MSB     = 7;
    localparam int WD_LSB     = 1;
    localparam int B_GUARD    = 7;
    localparam int HOLD_MSB   = 6;
    localparam int HOLD_LSB   = 4;
    localparam int FILT_MSB   = 3;
    localparam int FILT_LSB   = 0;
    localparam int SETUP_MSB  = 7;
    localparam int SETUP_LSB  = 4;
    localparam int DLY_MSB    = 3;
    localparam int DLY_LSB    = 2;
    localparam int B_FAST     = 1;
    localparam int B_BUS_OFF  = 0;

    // Timing figures in their own units and derived cycle counts.
    localparam int CC_UNIT_US    = 2000;
    localparam int CC_UNIT_CYC   = CC_UNIT_US * 1000 / CLK_NS;
    localparam int BUS_FAST_US   = 50;
    localparam int BUS_FAST_CYC  = BUS_FAST_US * 1000 / CLK_NS;
    localparam int BUS_SLOW_MS   = 1000;
    localparam int BUS_SLOW_CYC  = BUS_SLOW_MS * 1000 * 1000 / CLK_NS;
    localparam int FILT_NS       = 5;
    localparam int DLY_BASE_NS   = 240;
    localparam int DLY_STEP_NS   = 40;
    localparam int SETUP_BASE_NS = 80;
    localparam int SETUP_STEP_NS = 640;
    localparam int SCL_EXTRA     = 4;
    localparam int CLEAR_PULSES  = 9;

    typedef enum logic [1:0] {
        CC_IDLE,
        CC_XFER,
        CC_CLEAR
    } ccic_mode_t;

    // Converts a least time in nanoseconds to whole clock cycles.
    function automatic int ns2cyc_up(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction : ns2cyc_up

endpackage : ccic_pkg
`default_nettype wire

/* design/ccic_glitch.sv */
`timescale 1ns/10ps
`default_nettype none
module ccic_glitch (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       din,
    input  wire logic [3:0] depth,
    output logic            dout
);

    typedef struct packed {
        logic       q;
        logic [2:0] cnt;
    } ccic_filt_t;

    ccic_filt_t s_r;
    ccic_filt_t s_nxt;

    // A new level is taken only once it outlasts the glitch width.
    always_comb begin
        int need;
        need = ccic_pkg::ns2cyc_up(int'(depth) * ccic_pkg::FILT_NS);
        s_nxt = s_r;
        if (din == s_r.q) begin
            s_nxt.cnt = 3'h0;
        end else if (int'(s_r.cnt) >= need) begin // RULE_07
            s_nxt.q   = din;
            s_nxt.cnt = 3'h0;
        end else begin
            s_nxt.cnt = s_r.cnt + 3'h1;
        end
    end

    // Idle bus level is high, so the filter starts there.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '{q: 1'b1, cnt: 3'h0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.q;

endmodule : ccic_glitch
`default_nettype wire

/* design/ccic_sclgen.sv */
`timescale 1ns/10ps
`default_nettype none
module ccic_sclgen (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [7:0] high_time,
    input  wire logic [7:0] low_time,
    input  wire logic [7:0] min_low,
    output logic            scl_low,
    output logic            fall
);

    typedef struct packed {
        logic       low;
        logic       fall;
        logic [8:0] cnt;
    } ccic_gen_t;

    ccic_gen_t  s_r;
    ccic_gen_t  s_nxt;
    logic [8:0] hi_len;
    logic [8:0] lo_len;

    // Phase lengths include the four extra oscillator periods.
    always_comb begin
        hi_len = {1'b0, high_time} + 9'(ccic_pkg::SCL_EXTRA); // RULE_13
        lo_len = {1'b0, low_time} + 9'(ccic_pkg::SCL_EXTRA); // RULE_15
        if ({1'b0, min_low} > lo_len) begin
            lo_len = {1'b0, min_low};
        end
    end

    // Each run starts high so a fresh run never gives a runt low.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.fall = 1'b0;
        if (!run) begin
            s_nxt.low = 1'b0;
            s_nxt.cnt = 9'h000;
        end else if (s_r.cnt + 9'h001 >= (s_r.low ? lo_len : hi_len)) begin
            s_nxt.low  = !s_r.low;
            s_nxt.fall = !s_r.low;
            s_nxt.cnt  = 9'h000;
        end else begin
            s_nxt.cnt = s_r.cnt + 9'h001;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '{low: 1'b0, fall: 1'b0, cnt: 9'h000};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign scl_low = s_r.low;
    assign fall    = s_r.fall;

endmodule : ccic_sclgen
`default_nettype wire

/* design/ccic_top.sv */
// Overview of operation
// (RULE_01) Count parity errors; flag at 16-bit threshold.
// (RULE_02) Abort channel transactions exceeding watchdog time.
// (RULE_03) Watchdog timeout field bits 7:1, 2 ms.
// (RULE_04) Bit 0 set stops channel watchdog.
// (RULE_05) Guard bit rejects remote register writes.
// (RULE_06) SDA input hold: field 6:4 times 40 ns.
// (RULE_07) Filter input glitches of depth times 5 ns.
// (RULE_08) Lengthen ack SDA setup in 640 ns steps.
// (RULE_09) SDA output delay 240 ns plus 40 ns steps.
// (RULE_10) Bus watchdog: 50 us fast, 1 s slow.
// (RULE_11) SDA high and quiet means bus free.
// (RULE_12) SDA stuck low: drive nine SCL pulses.
// (RULE_13) SCL high lasts high value plus four.
// (RULE_14) Software allows ten percent oscillator error.
// (RULE_15) SCL low lasts low value plus four.
// (RULE_16) High threshold byte supplies bits 15:8.
// (RULE_17) Watchdog expiry releases bus, returns idle.
// (RULE_18) Parity logic on oscillator clock; flag sticky.
`timescale 1ns/10ps
`default_nettype none
module ccic_top #(
    parameter int CC_UNIT_CYC  = ccic_pkg::CC_UNIT_CYC,
    parameter int BUS_SLOW_CYC = ccic_pkg::BUS_SLOW_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       reg_wr,
    input  wire logic       reg_remote,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_reject,
    input  wire logic [1:0] par_err,
    input  wire logic [1:0] par_clr,
    output logic      [1:0] par_flag,
    input  wire logic       cc_busy,
    input  wire logic       ack_cycle,
    output logic            cc_abort,
    input  wire logic       mst_req,
    input  wire logic       mst_sda,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            bus_free
);

    typedef struct packed {
        logic                 scl_m;
        logic                 scl_s;
        logic                 sda_m;
        logic                 sda_s;
        logic [6:0]           hist;
        logic                 scl_d;
        logic                 sda_d;
        logic [7:0]           thr_hi;
        logic [7:0]           thr_lo;
        logic [7:0]           wdog;
        logic [7:0]           ctl1;
        logic [7:0]           ctl2;
        logic [7:0]           high;
        logic [7:0]           low;
        logic [1:0][15:0]     pcnt;
        logic [1:0]           pflag;
        ccic_pkg::ccic_mode_t mode;
        logic [15:0]          cc_tick;
        logic [6:0]           cc_units;
        logic                 cc_blk;
        logic                 cc_abort;
        logic [24:0]          bt;
        logic                 bus_free;
        logic [3:0]           pulses;
        logic                 sda_oe;
        logic                 pend;
        logic [4:0]           dly;
        logic [7:0]           rdata;
        logic                 reject;
        logic                 scl_oe;
        logic                 drv;
    } ccic_state_t;

    ccic_state_t s_r;
    ccic_state_t s_nxt;
    logic        scl_f;
    logic        sda_f;
    logic        sda_h;
    logic        gen_low;
    logic        gen_fall;
    logic [7:0]  min_low;
    logic [4:0]  dly_cyc;
    logic [15:0] thr;
    logic        activity;
    int          hold;
    int          limit;

    // Both lines pass a glitch filter after their synchronisers.
    ccic_glitch u_scl_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   (s_r.scl_s),
        .depth (s_r.ctl1[ccic_pkg::FILT_MSB:ccic_pkg::FILT_LSB]),
        .dout  (scl_f)
    );

    ccic_glitch u_sda_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   (s_r.sda_s),
        .depth (s_r.ctl1[ccic_pkg::FILT_MSB:ccic_pkg::FILT_LSB]),
        .dout  (sda_f)
    );

    // The clock generator serves normal transfers and the bus clear.
    ccic_sclgen u_gen (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .run       (s_r.mode != ccic_pkg::CC_IDLE),
        .high_time (s_r.high),
        .low_time  (s_r.low),
        .min_low   (min_low),
        .scl_low   (gen_low),
        .fall      (gen_fall)
    );

    // Derived timing values taken from the control fields.
    always_comb begin
        hold = int'(s_r.ctl1[ccic_pkg::HOLD_MSB:ccic_pkg::HOLD_LSB]);
        sda_h = (hold == 0) ? sda_f : s_r.hist[hold - 1]; // RULE_06
        dly_cyc = 5'(ccic_pkg::ns2cyc_up(ccic_pkg::DLY_BASE_NS +
            ccic_pkg::DLY_STEP_NS *
            int'(s_r.ctl2[ccic_pkg::DLY_MSB:ccic_pkg::DLY_LSB]))); // RULE_09
        // Ack setup covers the output delay plus the programmed setup.
        min_low = 8'h00;
        if (ack_cycle && cc_busy) begin
            min_low = 8'(int'(dly_cyc) + ccic_pkg::ns2cyc_up(
                ccic_pkg::SETUP_BASE_NS + ccic_pkg::SETUP_STEP_NS *
                int'(s_r.ctl2[ccic_pkg::SETUP_MSB:ccic_pkg::SETUP_LSB])));
        end // RULE_08
        thr = {s_r.thr_hi, s_r.thr_lo}; // RULE_16
        limit = s_r.ctl2[ccic_pkg::B_FAST] ? ccic_pkg::BUS_FAST_CYC
                                           : BUS_SLOW_CYC; // RULE_10
        activity = (scl_f != s_r.scl_d) || (sda_h != s_r.sda_d);
    end

    // Next-state logic for the whole block.
    always_comb begin
        s_nxt          = s_r;
        s_nxt.cc_abort = 1'b0;
        s_nxt.reject   = 1'b0;
        s_nxt.scl_m    = scl_in;
        s_nxt.scl_s    = s_r.scl_m;
        s_nxt.sda_m    = sda_in;
        s_nxt.sda_s    = s_r.sda_m;
        s_nxt.hist     = {s_r.hist[5:0], sda_f};
        s_nxt.scl_d    = scl_f;
        s_nxt.sda_d    = sda_h;

        // Register writes; remote writes are refused under the guard.
        if (reg_wr) begin
            if (reg_remote && s_r.ctl1[ccic_pkg::B_GUARD]) begin
                s_nxt.reject = 1'b1; // RULE_05
            end else begin
                case (reg_addr)
                    ccic_pkg::A_THR_HI: s_nxt.thr_hi = reg_wdata;
                    ccic_pkg::A_THR_LO: s_nxt.thr_lo = reg_wdata;
                    ccic_pkg::A_WDOG:   s_nxt.wdog   = reg_wdata;
                    ccic_pkg::A_CTL1:   s_nxt.ctl1   = reg_wdata;
                    ccic_pkg::A_CTL2:   s_nxt.ctl2   = reg_wdata;
                    ccic_pkg::A_HIGH:   s_nxt.high   = reg_wdata;
                    ccic_pkg::A_LOW:    s_nxt.low    = reg_wdata;
                    default: ;
                endcase
            end
        end

        // Read data follows the address one cycle later.
        case (reg_addr)
            ccic_pkg::A_THR_HI: s_nxt.rdata = s_r.thr_hi;
            ccic_pkg::A_THR_LO: s_nxt.rdata = s_r.thr_lo;
            ccic_pkg::A_WDOG:   s_nxt.rdata = s_r.wdog;
            ccic_pkg::A_CTL1:   s_nxt.rdata = s_r.ctl1;
            ccic_pkg::A_CTL2:   s_nxt.rdata = s_r.ctl2;
            ccic_pkg::A_HIGH:   s_nxt.rdata = s_r.high;
            ccic_pkg::A_LOW:    s_nxt.rdata = s_r.low;
            default:            s_nxt.rdata = ccic_pkg::R_ZERO;
        endcase

        // Parity counters saturate; a clear restarts the count but an
        // error in the same cycle is still counted, so set wins.
        for (int p = 0; p < 2; p++) begin
            if (par_clr[p]) begin
                s_nxt.pcnt[p] = par_err[p] ? 16'h0001 : 16'h0000;
            end else if (par_err[p] && s_r.pcnt[p] != 16'hFFFF) begin
                s_nxt.pcnt[p] = s_r.pcnt[p] + 16'h0001; // RULE_18
            end
            s_nxt.pflag[p] = (s_r.pflag[p] && !par_clr[p]) ||
                             (s_nxt.pcnt[p] >= thr); // RULE_01
        end

        // Mode sequencing for local controller work and bus clear.
        case (s_r.mode)
            ccic_pkg::CC_IDLE: begin
                if (mst_req && !s_r.cc_blk) begin
                    s_nxt.mode = ccic_pkg::CC_XFER;
                end
            end
            ccic_pkg::CC_XFER: begin
                if (!mst_req) begin
                    s_nxt.mode = ccic_pkg::CC_IDLE;
                end
            end
            ccic_pkg::CC_CLEAR: begin
                if (gen_fall) begin
                    s_nxt.pulses = s_r.pulses + 4'h1;
                end
                if (int'(s_r.pulses) >= ccic_pkg::CLEAR_PULSES &&
                    !gen_low) begin
                    s_nxt.mode = ccic_pkg::CC_IDLE; // RULE_12
                end
            end
            default: s_nxt.mode = ccic_pkg::CC_IDLE;
        endcase

        // Bus watchdog runs only while the block itself is idle.
        if (s_r.ctl2[ccic_pkg::B_BUS_OFF] || activity ||
            s_r.mode != ccic_pkg::CC_IDLE) begin
            s_nxt.bt = 25'h0000000;
            if (activity) begin
                s_nxt.bus_free = 1'b0;
            end
        end else if (int'(s_r.bt) >= limit - 1) begin
            s_nxt.bt = 25'h0000000;
            if (sda_h) begin
                s_nxt.bus_free = 1'b1; // RULE_11
            end else begin
                s_nxt.mode   = ccic_pkg::CC_CLEAR; // RULE_12
                s_nxt.pulses = 4'h0;
            end
        end else begin
            s_nxt.bt = s_r.bt + 25'h0000001;
        end

        // Channel watchdog; the block stays blocked until the channel
        // drops its busy level, so a late request cannot restart.
        if (!cc_busy) begin
            s_nxt.cc_tick  = 16'h0000;
            s_nxt.cc_units = 7'h00;
            s_nxt.cc_blk   = 1'b0;
        end else if (!s_r.wdog[ccic_pkg::B_WD_OFF] && !s_r.cc_blk) begin
            if (int'(s_r.cc_tick) >= CC_UNIT_CYC - 1) begin // RULE_04
                s_nxt.cc_tick  = 16'h0000;
                s_nxt.cc_units = s_r.cc_units + 7'h01;
                if (s_r.cc_units + 7'h01 >=
                    s_r.wdog[ccic_pkg::WD_MSB:ccic_pkg::WD_LSB]) begin
                    s_nxt.cc_abort = 1'b1; // RULE_02 RULE_03
                    s_nxt.cc_blk   = 1'b1;
                end
            end else begin
                s_nxt.cc_tick = s_r.cc_tick + 16'h0001;
            end
        end
        if (s_nxt.cc_abort) begin
            s_nxt.mode = ccic_pkg::CC_IDLE; // RULE_17
        end

        // SDA output changes a fixed delay after our own falling SCL.
        if (gen_fall && s_r.mode == ccic_pkg::CC_XFER) begin
            s_nxt.dly  = dly_cyc; // RULE_09
            s_nxt.pend = !mst_sda;
        end else if (s_r.dly != 5'h00) begin
            s_nxt.dly = s_r.dly - 5'h01;
            if (s_r.dly == 5'h01) begin
                s_nxt.sda_oe = s_r.pend;
            end
        end
        if (s_nxt.mode != ccic_pkg::CC_XFER) begin
            s_nxt.sda_oe = 1'b0; // RULE_17
            s_nxt.dly    = 5'h00;
        end
        s_nxt.scl_oe = gen_low;
    end

    // Single state register; the clock enable freezes everything.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.scl_m  <= 1'b1;
            s_r.scl_s  <= 1'b1;
            s_r.sda_m  <= 1'b1;
            s_r.sda_s  <= 1'b1;
            s_r.hist   <= '1;
            s_r.scl_d  <= 1'b1;
            s_r.sda_d  <= 1'b1;
            s_r.thr_hi <= ccic_pkg::R_THR_HI;
            s_r.thr_lo <= ccic_pkg::R_THR_LO;
            s_r.wdog   <= ccic_pkg::R_WDOG;
            s_r.ctl1   <= ccic_pkg::R_CTL1;
            s_r.ctl2   <= ccic_pkg::R_CTL2;
            s_r.high   <= ccic_pkg::R_HIGH;
            s_r.low    <= ccic_pkg::R_LOW;
            s_r.mode   <= ccic_pkg::CC_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata  = s_r.rdata;
    assign reg_reject = s_r.reject;
    assign par_flag   = s_r.pflag;
    assign cc_abort   = s_r.cc_abort;
    assign scl_out    = s_r.drv;
    assign scl_oe     = s_r.scl_oe;
    assign sda_out    = s_r.drv;
    assign sda_oe     = s_r.sda_oe;
    assign bus_free   = s_r.bus_free;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence scl_high_min;
        (!scl_oe)[*4];
    endsequence

    sequence scl_low_min;
        (scl_oe || s_r.mode == ccic_pkg::CC_IDLE)[*4];
    endsequence

    par_set_a: assert property ((s_r.pcnt[0] >= thr) && !par_clr[0]
        |=> par_flag[0]) // RULE_01
        else $error("parity flag missed at threshold");

    par_sticky_a: assert property (par_flag[1] && !par_clr[1]
        |=> par_flag[1]) // RULE_18
        else $error("parity flag dropped without clear");

    cc_limit_a: assert property (cc_busy && !s_r.cc_blk
        |-> s_r.cc_units <= s_r.wdog[ccic_pkg::WD_MSB:ccic_pkg::WD_LSB]
        || s_r.wdog[ccic_pkg::B_WD_OFF]) // RULE_02
        else $error("channel watchdog overran its limit");

    cc_off_a: assert property (cc_abort
        |-> !$past(s_r.wdog[ccic_pkg::B_WD_OFF])) // RULE_04
        else $error("abort while watchdog disabled");

    cc_release_a: assert property (cc_abort
        |-> !sda_oe ##[1:2] !scl_oe) // RULE_17
        else $error("bus held after channel abort");

    guard_a: assert property (reg_wr && reg_remote
        && s_r.ctl1[ccic_pkg::B_GUARD]
        |=> reg_reject && $stable(s_r.wdog)) // RULE_05
        else $error("guarded remote write not refused");

    scl_high_a: assert property ($fell(scl_oe)
        |-> scl_high_min) // RULE_13
        else $error("SCL high phase too short");

    scl_low_a: assert property ($rose(scl_oe)
        |-> scl_low_min) // RULE_15
        else $error("SCL low phase too short");

    bus_free_a: assert property ($rose(bus_free)
        |-> $past(sda_h) && !$past(activity)) // RULE_11
        else $error("bus free without quiet high SDA");

    clear_count_a: assert property (s_r.mode == ccic_pkg::CC_CLEAR
        |-> int'(s_r.pulses) <= ccic_pkg::CLEAR_PULSES) // RULE_12
        else $error("bus clear gave too many pulses");

    bus_timer_a: assert property ($stable(s_r.ctl2[ccic_pkg::B_FAST])
        |-> int'(s_r.bt) < limit) // RULE_10
        else $error("bus watchdog counted past expiry");

endmodule : ccic_top
`default_nettype wire

/* test/ccic_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Local bus peer: pull-ups, a target that can hang SDA, a clocking peer.
module ccic_bus_model (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic stuck,
    input  wire logic run,
    output logic      scl_line,
    output logic      sda_line
);
    logic scl_ext = 1'b1;

    // The peer clock toggles only while asked, so the line idles high.
    always #160 scl_ext = run ? ~scl_ext : 1'b1;

    // Open-drain wires: whoever pulls low wins over the pull-up.
    assign scl_line = ~scl_oe & scl_ext;
    assign sda_line = ~(sda_oe | stuck);
endmodule : ccic_bus_model
`default_nettype wire

/* test/control_channel_i2c_config_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module control_channel_i2c_config_test;
    logic       clk, rst_n, reg_wr, reg_remote, cc_busy, mst_req;
    logic       stuck, run, reg_reject, cc_abort, scl_out, scl_oe;
    logic       sda_out, sda_oe, bus_free, scl_line, sda_line, prev;
    logic       ce, ack_cycle, mst_sda;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] par_err, par_clr, par_flag;
    int         errors, n_tests, rejects, n, k;
    longint     t0;

    ccic_top #(.CC_UNIT_CYC(8), .BUS_SLOW_CYC(2000)) u_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
        .reg_remote(reg_remote), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_reject(reg_reject), .par_err(par_err), .par_clr(par_clr),
        .par_flag(par_flag), .cc_busy(cc_busy), .ack_cycle(ack_cycle),
        .cc_abort(cc_abort), .mst_req(mst_req), .mst_sda(mst_sda),
        .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_free(bus_free));

    ccic_bus_model u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .stuck(stuck),
        .run(run), .scl_line(scl_line), .sda_line(sda_line));

    // Reset values of 0x05 to 0x0B in address order.
    localparam logic [7:0] RST [7] = '{8'h01, 8'h00, 8'hFE, 8'h1C,
                                       8'h10, 8'h7A, 8'h7A};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Refused writes are tallied here since the flag lasts one cycle.
    always @(posedge clk) if (reg_reject === 1'b1) rejects++;

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic rem);
        @(posedge clk);
        reg_wr     <= 1'b1;
        reg_addr   <= a;
        reg_wdata  <= d;
        reg_remote <= rem;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic ck(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 `CHK(reg_rdata, e)
    endtask : ck

    task automatic end_of_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // The whole sequence needs about 7500 cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end

    // Main sequence of register, parity, watchdog and bus checks.
    initial begin
        {rst_n, reg_wr, reg_remote, cc_busy, mst_req, stuck, run} = '0;
        {ce, ack_cycle, mst_sda} = 3'b100;
        {reg_addr, reg_wdata, par_err, par_clr} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t0 = $time;
        for (int i = 0; i < 7; i++) ck(8'h05 + 8'(i), RST[i]);
        while (bus_free !== 1'b1 && $time - t0 < 120000) @(posedge clk);
        n = int'(($time - t0) / 40);
        `CHK(n >= 2000 && n <= 2030, 1'b1)
        wr(8'h09, 8'h12, 1'b0);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        run <= 1'b0;
        #1 `CHK(bus_free, 1'b0)
        n = 0;
        while (bus_free !== 1'b1 && n < 1500) begin @(posedge clk); n++; end
        `CHK(n >= 1250 && n <= 1280, 1'b1)
        @(posedge clk);
        stuck <= 1'b1;
        n = 0;
        while (scl_oe !== 1'b1 && n < 1500) begin @(posedge clk); n++; end
        // The clear opens with a full high phase after the 1250-cycle limit.
        `CHK(n >= 1376 && n <= 1400, 1'b1)
        k = 1;
        prev = 1'b1;
        repeat (2600) begin
            @(posedge clk);
            if (scl_oe === 1'b1 && !prev) k++;
            prev = scl_oe;
        end
        `CHK(k, 9)
        `CHK({scl_out, sda_out}, 2'b00)
        stuck <= 1'b0;
        wr(8'h20, 8'hFF, 1'b0);
        ck(8'h20, 8'h00);
        // Low byte first, so the live threshold never passes through zero.
        wr(8'h06, 8'h03, 1'b1);
        wr(8'h05, 8'h00, 1'b0);
        wr(8'h08, 8'h9C, 1'b0);
        wr(8'h0A, 8'h55, 1'b1);
        wr(8'h08, 8'h1C, 1'b1);
        ck(8'h0A, 8'h7A);
        ck(8'h08, 8'h9C);
        `CHK(rejects, 2)
        wr(8'h0A, 8'h02, 1'b0);
        wr(8'h0B, 8'h03, 1'b0);
        ck(8'h06, 8'h03);
        @(posedge clk);
        par_err <= 2'b01;
        repeat (2) @(posedge clk);
        #1 `CHK(par_flag, 2'b00)
        @(posedge clk);
        par_err <= 2'b00;
        @(posedge clk);
        #1 `CHK(par_flag, 2'b01)
        repeat (20) @(posedge clk);
        `CHK(par_flag, 2'b01)
        @(posedge clk);
        par_clr <= 2'b01;
        @(posedge clk);
        par_clr <= 2'b00;
        @(posedge clk);
        #1 `CHK(par_flag, 2'b00)
        // A frozen block must not count errors while the enable is low.
        @(posedge clk);
        ce      <= 1'b0;
        par_err <= 2'b01;
        repeat (3) @(posedge clk);
        ce      <= 1'b1;
        par_err <= 2'b00;
        repeat (2) @(posedge clk);
        #1 `CHK(par_flag, 2'b00)
        wr(8'h07, 8'h02, 1'b0);
        @(posedge clk);
        cc_busy <= 1'b1;
        mst_req <= 1'b1;
        n = 0;
        do begin @(posedge clk); #1 n++; end
        while (cc_abort !== 1'b1 && n < 40);
        `CHK(n >= 8 && n <= 9, 1'b1)
        `CHK(sda_oe, 1'b0)
        repeat (2) @(posedge clk);
        #1 `CHK(scl_oe, 1'b0)
        @(posedge clk);
        cc_busy <= 1'b0;
        mst_req <= 1'b0;
        wr(8'h07, 8'h03, 1'b0);
        @(posedge clk);
        cc_busy <= 1'b1;
        n = 0;
        repeat (40) begin @(posedge clk); if (cc_abort === 1'b1) n++; end
        `CHK(n, 0)
        cc_busy <= 1'b0;
        mst_req <= 1'b1;
        n = 0;
        while (scl_oe !== 1'b1 && n < 300) begin @(posedge clk); #1 n++; end
        n = 0;
        k = 0;
        while (scl_oe === 1'b1 && n < 99) begin
            @(posedge clk);
            #1 n++;
            if (sda_oe === 1'b1 && k == 0) k = n;
        end
        `CHK(n, 7)
        `CHK(k, 6)
        n = 0;
        while (scl_oe !== 1'b1 && n < 99) begin @(posedge clk); #1 n++; end
        `CHK(n, 6)
        `CHK(sda_oe, 1'b1)
        // Ack cycles of a remote access stretch the low phase.
        @(posedge clk);
        ack_cycle <= 1'b1;
        cc_busy   <= 1'b1;
        mst_sda   <= 1'b1;
        while (scl_oe !== 1'b0) begin @(posedge clk); #1; end
        while (scl_oe !== 1'b1) begin @(posedge clk); #1; end
        n = 0;
        while (scl_oe === 1'b1 && n < 99) begin @(posedge clk); #1 n++; end
        `CHK(n, 24)
        `CHK(sda_oe, 1'b0)
        @(posedge clk);
        mst_req <= 1'b0;
        end_of_test();
    end
endmodule : control_channel_i2c_config_test
`default_nettype wire
